// file: pts_defines.svh
`ifndef PTS_DEFINES_SVH
`define PTS_DEFINES_SVH

// Register byte addresses
`define PTS_ADDR_COUNT    4'h0
`define PTS_ADDR_PERIOD   4'h4
`define PTS_ADDR_MAIN     4'h8
`define PTS_ADDR_CTRL1    4'hC
`define PTS_ADDR_HLT      5'h10
`define PTS_ADDR_RSTSEL   5'h14
`define PTS_ADDR_W        5

// Reset values
`define PTS_COUNT_RST     8'h00
`define PTS_PERIOD_RST    8'hFF
`define PTS_MAIN_RST      8'h00
`define PTS_CTRL1_RST     8'h00
`define PTS_HLT_RST       5'h00
`define PTS_RSTSEL_RST    2'h0

// Main control fields
`define PTS_MAIN_RUN      7
`define PTS_MAIN_PRE_HI   1
`define PTS_MAIN_PRE_LO   0
// Control one fields
`define PTS_PS_HI         4
`define PTS_PS_LO         0

// Prescaler divide: 1, 4, 16, 64 selects terminal count
`define PTS_PRE_W         6
`define PTS_PRE_TC1       6'h00
`define PTS_PRE_TC4       6'h03
`define PTS_PRE_TC16      6'h0F
`define PTS_PRE_TC64      6'h3F

// External source choices
`define PTS_SRC_W         2

`endif

// file: pts_ext_model.sv
module pts_ext_model
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Trigger request and chosen line
    input  wire logic       trigReq,
    input  wire logic [1:0] selIdx,
    // Source lines toward the timer
    output logic [3:0]      extSrc
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] holdCnt;
    logic [2:0] gapCnt;
    logic       active;
    logic       noise;

    // Level stretched to four ticks or more, then low seven ticks or more
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active  <= 1'b0;
            holdCnt <= 2'h0;
            gapCnt  <= 3'h6;
        end
        else if (!active)
        begin
            gapCnt <= (gapCnt == 3'h6) ? gapCnt : gapCnt + 3'h1;
            if (trigReq && gapCnt == 3'h6)
            begin
                active  <= 1'b1;
                holdCnt <= 2'h3;
                gapCnt  <= 3'h0;
            end
        end
        else if (holdCnt != 2'h0)
            holdCnt <= holdCnt - 2'h1;
        else if (!trigReq)
            active <= 1'b0;
    end

    // Unselected lines toggle, so a wrong select cannot pass unseen
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            noise <= 1'b0;
        else
            noise <= ~noise;
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            extSrc[i] = (i == int'(selIdx)) ? active : noise ^ i[0];
    end
endmodule

// file: pts_ext_sync.sv
`include "pts_defines.svh"

module pts_ext_sync
(
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    // Raw sources and selection
    input  wire logic [3:0]             srcRaw,
    input  wire logic [`PTS_SRC_W-1:0]  srcSel,
    // Synchronised level and rising edge
    output logic                        srcLevel,
    output logic                        srcRise
);
    logic [3:0] stage1;
    logic [3:0] stage2;
    logic       levelDly;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= 4'h0;
            stage2 <= 4'h0;
        end
        else
        begin
            stage1 <= srcRaw;
            stage2 <= stage1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            levelDly <= 1'b0;
        end
        else
        begin
            levelDly <= stage2[srcSel];
        end
    end

    assign srcLevel = stage2[srcSel];
    assign srcRise  = stage2[srcSel] & ~levelDly;
endmodule

// file: pts_pkg.sv
`include "pts_defines.svh"

package pts_pkg;
    typedef enum logic [4:0] {
        PTS_FREE_SW       = 5'h00,
        PTS_FREE_GATE_HI  = 5'h01,
        PTS_FREE_GATE_LO  = 5'h02,
        PTS_FREE_RST_EDGE = 5'h03,
        PTS_FREE_RST_HI   = 5'h06,
        PTS_ONESHOT_SW    = 5'h08,
        PTS_ONESHOT_RST   = 5'h0B,
        PTS_MONO_EDGE     = 5'h11
    } pts_mode_t;

    typedef struct packed {
        logic [7:0] count;
        logic       match;
        logic       tick;
        logic       running;
    } pts_pwm_t;

    typedef struct packed {
        logic [`PTS_ADDR_W-1:0] adr;
        logic [31:0]            dat;
        logic [3:0]             sel;
        logic                   we;
        logic                   cyc;
        logic                   stb;
    } pts_wb_req_t;
endpackage

// file: pts_timer.sv
// Local design decisions: the Wishbone register port and the address map.
`include "pts_defines.svh"

// Functional notes
// - Free-running, one-shot and monostable modes with start/stop/reset options.
// - Count increments on each prescaled timer tick.
// - Match flags the postscaler; count clears on the following tick.
// - Gated modes hold the count while the gate is inactive.
// - Reset modes clear the count on level or edge of the source.
// - Count and period readable and writable; reset gives 00 and FF.
// - Count write, main control write, reset, external reset clear pre/postscalers.
// - Main control write leaves the count unchanged.
// - Free-running match returns count to zero and advances the postscaler.
// - Postscaler equal to setting emits one-tick pulse and clears.
// - One-shot match clears the run bit and stops counting.
// - One-shot postscale nonzero never emits a pulse; postscaler resets on restart.
// - Monostable match stops without clearing run; external reset restarts.
// - Live count and timing signals exported to the PWM unit.
// - External triggers ignored during debug freeze.
// - Five-bit mode field in the hardware-limit control register.
module pts_timer
    import pts_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Wishbone slave
    input  wire pts_pkg::pts_wb_req_t  wbReq,
    output logic [31:0]                wbDatO,
    output logic                       wbAck,
    // External sources and debug
    input  wire logic [3:0]            extSrc,
    input  wire logic                  debugFreeze,
    // Consumers
    output logic                       postscaledPulse,
    output pts_pkg::pts_pwm_t          pwmLink
);
    import pts_pkg::*;

    logic [7:0]              timerCount;
    logic [7:0]              periodValue;
    logic [7:0]              mainControl;
    logic [7:0]              controlOne;
    logic [4:0]              hardwareLimitControl;
    logic [`PTS_SRC_W-1:0]   externalResetSelect;
    logic [`PTS_PRE_W-1:0]   preCount;
    logic [4:0]              postCount;
    logic                    monoStopped;
    logic                    freezeS1;
    logic                    freezeS2;
    logic                    srcLevel;
    logic                    srcRise;
    logic                    access;
    logic                    wrCount;
    logic                    wrMain;
    logic                    tick;
    logic                    match;
    logic                    gateOk;
    logic                    extReset;
    logic                    runBit;
    logic                    counting;
    pts_mode_t               mode;

    function automatic logic [`PTS_PRE_W-1:0] preTerminal(input logic [1:0] sel);
        unique case (sel)
            2'h0:    preTerminal = `PTS_PRE_TC1;
            2'h1:    preTerminal = `PTS_PRE_TC4;
            2'h2:    preTerminal = `PTS_PRE_TC16;
            default: preTerminal = `PTS_PRE_TC64;
        endcase
    endfunction

    function automatic logic isWrite(input pts_wb_req_t r, input logic [`PTS_ADDR_W-1:0] a);
        isWrite = r.cyc && r.stb && r.we && r.sel[0] && !wbAck && (r.adr == a);
    endfunction

    pts_ext_sync u_sync
    (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .srcRaw   (extSrc),
        .srcSel   (externalResetSelect),
        .srcLevel (srcLevel),
        .srcRise  (srcRise)
    );

    // Freeze comes from the debug domain
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            freezeS1 <= 1'b0;
            freezeS2 <= 1'b0;
        end
        else
        begin
            freezeS1 <= debugFreeze;
            freezeS2 <= freezeS1;
        end
    end

    assign mode     = pts_mode_t'(hardwareLimitControl);
    assign access   = wbReq.cyc && wbReq.stb && !wbAck;
    assign wrCount  = isWrite(wbReq, `PTS_ADDR_W'(`PTS_ADDR_COUNT));
    assign wrMain   = isWrite(wbReq, `PTS_ADDR_W'(`PTS_ADDR_MAIN));
    assign runBit   = mainControl[`PTS_MAIN_RUN];
    assign tick     = (preCount == preTerminal(mainControl[`PTS_MAIN_PRE_HI:`PTS_MAIN_PRE_LO]));
    assign match    = (timerCount == periodValue);

    // Gate and reset decode; triggers masked under freeze
    always_comb
    begin
        gateOk   = 1'b1;
        extReset = 1'b0;
        unique case (mode)
            PTS_FREE_GATE_HI:  gateOk   = srcLevel | freezeS2;
            PTS_FREE_GATE_LO:  gateOk   = ~srcLevel | freezeS2;
            PTS_FREE_RST_EDGE: extReset = srcRise & ~freezeS2;
            PTS_FREE_RST_HI:   extReset = srcLevel & ~freezeS2;
            PTS_ONESHOT_RST:   extReset = srcRise & ~freezeS2;
            PTS_MONO_EDGE:     extReset = srcRise & ~freezeS2;
            default:           gateOk   = 1'b1;
        endcase
    end

    assign counting = runBit && gateOk && !monoStopped && !extReset && !wrMain;

    // Prescaler runs even when stopped, so a pulse still ends after one tick
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            preCount <= '0;
        end
        else if (wrCount || wrMain || extReset)
        begin
            preCount <= '0;
        end
        else
        begin
            preCount <= tick ? '0 : preCount + `PTS_PRE_W'(1);
        end
    end

    // Count register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timerCount <= `PTS_COUNT_RST;
        end
        else if (wrCount)
        begin
            timerCount <= wbReq.dat[7:0];
        end
        else if (extReset)
        begin
            timerCount <= `PTS_COUNT_RST;
        end
        else if (counting && tick)
        begin
            // Match clears on the next tick, else step
            timerCount <= match ? `PTS_COUNT_RST : timerCount + 8'h01;
        end
    end

    // Postscaler and output pulse
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            postCount       <= 5'h00;
            postscaledPulse <= 1'b0;
        end
        else if (wrCount || wrMain || extReset)
        begin
            postCount       <= 5'h00;
            postscaledPulse <= 1'b0;
        end
        else if (counting && tick)
        begin
            postscaledPulse <= 1'b0;
            if (match)
            begin
                // Pulse width one tick
                if (postCount == controlOne[`PTS_PS_HI:`PTS_PS_LO])
                begin
                    postCount       <= 5'h00;
                    postscaledPulse <= 1'b1;
                end
                else
                begin
                    postCount <= postCount + 5'h01;
                end
            end
        end
        else if (tick)
        begin
            postscaledPulse <= 1'b0;
        end
    end

    // Monostable hold flag
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            monoStopped <= 1'b0;
        end
        else if (extReset || wrMain)
        begin
            monoStopped <= 1'b0;
        end
        else if (counting && tick && match && mode == PTS_MONO_EDGE)
        begin
            monoStopped <= 1'b1;
        end
    end

    // Main control; a main write stalls the count, so the one-shot clear never meets it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mainControl <= `PTS_MAIN_RST;
        end
        else
        begin
            if (wrMain)
            begin
                mainControl <= wbReq.dat[7:0];
            end
            if (counting && tick && match
                && (mode == PTS_ONESHOT_SW || mode == PTS_ONESHOT_RST))
            begin
                mainControl[`PTS_MAIN_RUN] <= 1'b0;
            end
        end
    end

    // Remaining configuration registers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            periodValue          <= `PTS_PERIOD_RST;
            controlOne           <= `PTS_CTRL1_RST;
            hardwareLimitControl <= `PTS_HLT_RST;
            externalResetSelect  <= `PTS_RSTSEL_RST;
        end
        else
        begin
            if (isWrite(wbReq, `PTS_ADDR_W'(`PTS_ADDR_PERIOD)))
                periodValue <= wbReq.dat[7:0];
            if (isWrite(wbReq, `PTS_ADDR_W'(`PTS_ADDR_CTRL1)))
                controlOne <= {3'h0, wbReq.dat[4:0]};
            if (isWrite(wbReq, `PTS_ADDR_HLT))
                hardwareLimitControl <= wbReq.dat[4:0];
            if (isWrite(wbReq, `PTS_ADDR_RSTSEL))
                externalResetSelect <= wbReq.dat[`PTS_SRC_W-1:0];
        end
    end

    // Bus answer one cycle after strobe; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wbAck  <= 1'b0;
            wbDatO <= 32'h00000000;
        end
        else
        begin
            wbAck  <= access;
            wbDatO <= 32'h00000000;
            if (access && !wbReq.we)
            begin
                unique case (wbReq.adr)
                    `PTS_ADDR_W'(`PTS_ADDR_COUNT):  wbDatO <= {24'h000000, timerCount};
                    `PTS_ADDR_W'(`PTS_ADDR_PERIOD): wbDatO <= {24'h000000, periodValue};
                    `PTS_ADDR_W'(`PTS_ADDR_MAIN):   wbDatO <= {24'h000000, mainControl};
                    `PTS_ADDR_W'(`PTS_ADDR_CTRL1):  wbDatO <= {24'h000000, controlOne};
                    `PTS_ADDR_HLT:    wbDatO <= {27'h0000000, hardwareLimitControl};
                    `PTS_ADDR_RSTSEL: wbDatO <= {30'h00000000, externalResetSelect};
                    default:          wbDatO <= 32'h00000000;
                endcase
            end
        end
    end

    // Export to the PWM unit
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwmLink <= '0;
        end
        else
        begin
            pwmLink.count   <= timerCount;
            pwmLink.match   <= match;
            pwmLink.tick    <= counting && tick;
            pwmLink.running <= counting;
        end
    end

    property p_reset_clears;
        @(posedge mclk) disable iff (!rst_n)
        extReset && !wrCount |=> timerCount == 8'h00 && preCount == 6'h00;
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("ext reset no clear");

    property p_main_keeps;
        @(posedge mclk) disable iff (!rst_n)
        wrMain && !extReset |=> timerCount == $past(timerCount) && postCount == 5'h00;
    endproperty
    a_main_keeps: assert property (p_main_keeps) else $error("main write moved count");

    property p_wrap;
        @(posedge mclk) disable iff (!rst_n)
        counting && tick && match && !wrCount |=> timerCount == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap on match");

    property p_step;
        @(posedge mclk) disable iff (!rst_n)
        counting && tick && !match && !wrCount |=> timerCount == $past(timerCount) + 8'h01;
    endproperty
    a_step: assert property (p_step) else $error("count did not step");

    property p_gate_hold;
        @(posedge mclk) disable iff (!rst_n)
        !gateOk && !wrCount |=> timerCount == $past(timerCount);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate did not hold");

    property p_oneshot;
        @(posedge mclk) disable iff (!rst_n)
        counting && tick && match && mode == PTS_ONESHOT_SW |=> !runBit;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("run not cleared");

    property p_freeze;
        @(posedge mclk) disable iff (!rst_n)
        freezeS2 |-> !extReset;
    endproperty
    a_freeze: assert property (p_freeze) else $error("trigger under freeze");

    property p_pulse;
        @(posedge mclk) disable iff (!rst_n)
        $rose(postscaledPulse) |-> $past(match) && postCount == 5'h00;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse without match");

    property p_ack;
        @(posedge mclk) disable iff (!rst_n)
        access |=> wbAck ##1 !wbAck;
    endproperty
    a_ack: assert property (p_ack) else $error("ack timing");

    c_pulse:   cover property (@(posedge mclk) disable iff (!rst_n) $rose(postscaledPulse));
    c_oneshot: cover property (@(posedge mclk) disable iff (!rst_n) $fell(runBit));
    c_mono:    cover property (@(posedge mclk) disable iff (!rst_n) monoStopped ##1 !monoStopped);
    c_gate:    cover property (@(posedge mclk) disable iff (!rst_n) !gateOk && runBit);
endmodule

// file: test_period_timer_with_postscaler.sv
`include "pts_defines.svh"

module test_period_timer_with_postscaler;
    timeunit 1ns;
    timeprecision 1ps;
    import pts_pkg::*;

    logic        mclk;
    logic        rst_n;
    pts_wb_req_t wbReq;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic [3:0]  extSrc;
    logic        debugFreeze;
    logic        postscaledPulse;
    pts_pwm_t    pwmLink;
    logic        trigReq;
    logic [1:0]  selIdx;
    logic [3:0]  wsel;
    logic [32:0] notes[$];
    logic [32:0] note;
    logic [31:0] seed;
    logic        overRun;
    logic        prevPulse;
    int          pulseCnt;
    int          errors;
    int          total_checks;

    pts_timer dut_u (.mclk(mclk), .rst_n(rst_n), .wbReq(wbReq), .wbDatO(wbDatO),
        .wbAck(wbAck), .extSrc(extSrc), .debugFreeze(debugFreeze),
        .postscaledPulse(postscaledPulse), .pwmLink(pwmLink));
    pts_ext_model src_u (.mclk(mclk), .rst_n(rst_n), .trigReq(trigReq),
        .selIdx(selIdx), .extSrc(extSrc));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic timeout();
        errors++;
        $display("ERROR at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
        results();
    endtask

    // Reads note their expectation; the monitor compares on ack
    task automatic wb(input logic [4:0] adr, input logic we, input logic [31:0] dat,
                      input logic [31:0] exp);
        int n;
        notes.push_back({~we, exp});
        @(posedge mclk);
        wbReq <= '{adr: adr, dat: dat, sel: wsel, we: we, cyc: 1'b1, stb: 1'b1};
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
        if (n >= 20)
            timeout();
    endtask

    task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
        wb(adr, 1'b1, dat, 32'h0);
    endtask

    task automatic rd(input logic [4:0] adr, input logic [31:0] exp);
        wb(adr, 1'b0, 32'h0, exp);
    endtask

    // Kind 0: count equal, 1: count differs, 2: running equals v[0]
    task automatic wait_for(input int kind, input logic [7:0] v);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (!((kind == 0 && pwmLink.count === v) || (kind == 1 && pwmLink.count !== v)
                 || (kind == 2 && pwmLink.running === v[0])) && n < 300);
        if (n >= 300)
            timeout();
    endtask

    task automatic wait_rise(output int n, input logic [7:0] per);
        logic prev;
        n = 0;
        do
        begin
            prev = postscaledPulse;
            @(posedge mclk);
            n++;
            if (pwmLink.count > per)
                overRun = 1'b1;
        end
        while (!(postscaledPulse === 1'b1 && prev === 1'b0) && n < 5000);
        if (n >= 5000)
            timeout();
    endtask

    task automatic reset_regs();
        rd(`PTS_ADDR_COUNT, 32'(`PTS_COUNT_RST));
        rd(`PTS_ADDR_PERIOD, 32'(`PTS_PERIOD_RST));
        rd(`PTS_ADDR_MAIN, 32'(`PTS_MAIN_RST));
        rd(`PTS_ADDR_CTRL1, 32'(`PTS_CTRL1_RST));
        rd(`PTS_ADDR_HLT, 32'(`PTS_HLT_RST));
        rd(`PTS_ADDR_RSTSEL, 32'(`PTS_RSTSEL_RST));
    endtask

    always @(posedge mclk)
    begin
        if (wbAck === 1'b1 && notes.size() > 0)
        begin
            note = notes.pop_front();
            if (note[32])
                check(wbDatO, note[31:0]);
        end
        prevPulse <= postscaledPulse;
        if (postscaledPulse === 1'b1 && prevPulse === 1'b0)
            pulseCnt <= pulseCnt + 1;
    end

    initial
    begin
        int n;
        int w;
        int div;
        int base;
        logic [7:0] per;
        logic [4:0] ps;
        rst_n = 1'b0;
        wbReq = '0;
        debugFreeze = 1'b0;
        trigReq = 1'b0;
        seed = 32'd29524;
        selIdx = 2'h0;
        wsel = 4'hF;
        overRun = 1'b0;
        prevPulse = 1'b0;
        pulseCnt = 0;
        errors = 0;
        total_checks = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        reset_regs();
        wr(`PTS_ADDR_PERIOD, 32'h37);
        rd(`PTS_ADDR_PERIOD, 32'h37);
        wr(`PTS_ADDR_COUNT, 32'h12);
        wsel = 4'hE;
        wr(`PTS_ADDR_COUNT, 32'h55);
        wsel = 4'hF;
        rd(`PTS_ADDR_COUNT, 32'h12);
        wr(5'h18, 32'hFF);
        rd(5'h18, 32'h0);
        wr(`PTS_ADDR_MAIN, 32'h01);
        rd(`PTS_ADDR_COUNT, 32'h12);
        $display("test registers done");
        wr(`PTS_ADDR_HLT, 32'(PTS_FREE_SW));
        for (int p = 0; p < 4; p++)
        begin
            per = 8'(rnd() % 7 + 1);
            ps = 5'(rnd() % 4);
            div = 1 << (2 * p);
            wr(`PTS_ADDR_MAIN, 32'h0);
            wr(`PTS_ADDR_PERIOD, 32'(per));
            wr(`PTS_ADDR_CTRL1, 32'(ps));
            wr(`PTS_ADDR_COUNT, 32'h0);
            wr(`PTS_ADDR_MAIN, {24'h0, 1'b1, 5'h0, 2'(p)});
            wait_rise(n, per);
            wait_rise(n, per);
            check(n, div * (per + 1) * (ps + 1));
            w = 0;
            while (postscaledPulse === 1'b1 && w < 100)
            begin
                @(posedge mclk);
                w++;
            end
            check(w, div);
        end
        check(overRun, 1'b0);
        $display("test free running done");
        wr(`PTS_ADDR_MAIN, 32'h0);
        wr(`PTS_ADDR_HLT, 32'(PTS_ONESHOT_SW));
        wr(`PTS_ADDR_PERIOD, 32'h5);
        wr(`PTS_ADDR_CTRL1, 32'h3);
        wr(`PTS_ADDR_COUNT, 32'h0);
        base = pulseCnt;
        for (int r = 0; r < 4; r++)
        begin
            wr(`PTS_ADDR_MAIN, 32'h80);
            wait_for(2, 8'h1);
            wait_for(2, 8'h0);
            rd(`PTS_ADDR_MAIN, 32'h0);
        end
        check(pulseCnt - base, 0);
        $display("test one-shot done");
        wr(`PTS_ADDR_MAIN, 32'h0);
        selIdx <= 2'(rnd() % 4);
        @(posedge mclk);
        wr(`PTS_ADDR_RSTSEL, 32'(selIdx));
        wr(`PTS_ADDR_HLT, 32'(PTS_MONO_EDGE));
        wr(`PTS_ADDR_PERIOD, 32'h4);
        wr(`PTS_ADDR_CTRL1, 32'h0);
        for (int r = 0; r < 2; r++)
        begin
            repeat (8) @(posedge mclk);
            trigReq <= 1'b1;
            @(posedge mclk);
            trigReq <= 1'b0;
            if (r == 0)
                wr(`PTS_ADDR_MAIN, 32'h80);
            wait_for(2, 8'h1);
            wait_for(2, 8'h0);
            rd(`PTS_ADDR_MAIN, 32'h80);
        end
        $display("test monostable done");
        for (int g = 0; g < 2; g++)
        begin
            trigReq <= (g == 1);
            wr(`PTS_ADDR_MAIN, 32'h0);
            wr(`PTS_ADDR_HLT, (g == 1) ? 32'(PTS_FREE_GATE_LO) : 32'(PTS_FREE_GATE_HI));
            wr(`PTS_ADDR_PERIOD, 32'hFF);
            wr(`PTS_ADDR_COUNT, 32'h2);
            wr(`PTS_ADDR_MAIN, 32'h80);
            rd(`PTS_ADDR_COUNT, 32'h2);
            rd(`PTS_ADDR_COUNT, 32'h2);
            trigReq <= (g == 0);
            wait_for(1, 8'h2);
            check(pwmLink.count, 8'h3);
        end
        $display("test gate done");
        wr(`PTS_ADDR_MAIN, 32'h0);
        wr(`PTS_ADDR_HLT, 32'(PTS_FREE_RST_EDGE));
        wr(`PTS_ADDR_COUNT, 32'h80);
        wr(`PTS_ADDR_MAIN, 32'h80);
        trigReq <= 1'b1;
        @(posedge mclk);
        trigReq <= 1'b0;
        repeat (6) @(posedge mclk);
        check(pwmLink.count < 8'h08, 1'b1);
        wr(`PTS_ADDR_MAIN, 32'h0);
        wr(`PTS_ADDR_HLT, 32'(PTS_FREE_RST_HI));
        debugFreeze <= 1'b1;
        wr(`PTS_ADDR_COUNT, 32'h0);
        wr(`PTS_ADDR_MAIN, 32'h80);
        trigReq <= 1'b1;
        repeat (10) @(posedge mclk);
        check(pwmLink.count === 8'h00, 1'b0);
        debugFreeze <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(`PTS_ADDR_COUNT, 32'h0);
        rd(`PTS_ADDR_COUNT, 32'h0);
        trigReq <= 1'b0;
        $display("test external reset done");
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        reset_regs();
        $display("test second reset done");
        results();
    end
endmodule
